// *** common/tpd_defines.vh ***
// constants for the timer period/duty compare register block
`ifndef TPD_DEFINES_VH
`define TPD_DEFINES_VH

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define TPD_DATA_W      16
`define TPD_PRE_W       8
`define TPD_NUM_SUB     4
`define TPD_ADDR_W      4
`define TPD_RESET_VAL   16'h0000
`define TPD_PRE_RESET   8'h00
`define TPD_RDATA_IDLE  16'h0000

// ----------------------------------------
// byte offsets, word registers on even addresses
// ----------------------------------------
`define TPD_OFS_PERIOD_1  4'h0
`define TPD_OFS_PERIOD_2  4'h2
`define TPD_OFS_PERIOD_3  4'h4
`define TPD_OFS_PERIOD_4  4'h6
`define TPD_OFS_DUTY_1    4'h8
`define TPD_OFS_DUTY_2    4'hA
`define TPD_OFS_DUTY_3    4'hC
`define TPD_OFS_DUTY_4    4'hE

`endif

// *** logic/tpd_buffered_reg.v ***
// one double buffered compare / capture register
`timescale 1ns/1ps
`include "tpd_defines.vh"

module tpd_buffered_reg #(
  parameter DATA_W = `TPD_DATA_W
) (
  input  wire              ref_clk,
  input  wire              srst,
  input  wire              wr_en,
  input  wire [DATA_W-1:0] wdata,
  input  wire              pwm_mode,
  input  wire              stopped,
  input  wire              period_match,
  input  wire              capture_evt,
  input  wire [DATA_W-1:0] counter,
  output wire [DATA_W-1:0] read_value,
  output wire [DATA_W-1:0] active_value,
  output wire              pending
);

  reg  [DATA_W-1:0] shadow_reg;
  reg  [DATA_W-1:0] active_reg;
  reg               pending_reg;
  reg               capture_q_reg;
  wire              update_now;

  // stop or period match releases the buffer; both registers of a pair see the same match
  assign update_now   = stopped | period_match; // R3 R7 R11 R13
  assign read_value   = shadow_reg; // R4
  assign active_value = active_reg;
  assign pending      = pending_reg;

  // ----------------------------------------
  // shadow: last written or captured value
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      shadow_reg    <= `TPD_RESET_VAL; // R5 R8
      capture_q_reg <= 1'b0;
    end else begin
      capture_q_reg <= capture_evt & ~pwm_mode;
      // capture beats a write in the same cycle: hardware event is not lost
      if (capture_q_reg) begin
        shadow_reg <= counter; // R2 R6 R14
      end else if (wr_en) begin
        shadow_reg <= wdata; // R1 R6
      end
    end
  end

  // ----------------------------------------
  // active compare value seen by the pwm stage
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      active_reg  <= `TPD_RESET_VAL; // R5 R8
      pending_reg <= 1'b0;
    end else begin
      if (!pwm_mode) begin
        active_reg  <= shadow_reg;
        pending_reg <= 1'b0;
      end else if (wr_en && !stopped) begin
        // write while running waits for the next boundary
        pending_reg <= 1'b1; // R3 R7
        if (period_match) begin
          active_reg <= shadow_reg;
        end
      end else if (update_now) begin
        active_reg  <= shadow_reg; // R3 R7 R11
        pending_reg <= 1'b0;
      end
    end
  end

endmodule

// *** logic/tpd_prescaler.v ***
// clock prescaler for one timer subsystem
`timescale 1ns/1ps
`include "tpd_defines.vh"

module tpd_prescaler #(
  parameter PRE_W = `TPD_PRE_W
) (
  input  wire             ref_clk,
  input  wire             srst,
  input  wire             running,
  input  wire [PRE_W-1:0] prescale_compare_value,
  output wire             tick
);

  reg  [PRE_W-1:0] pre_cnt_reg;
  reg  [PRE_W-1:0] pre_cnt_next;

  // ----------------------------------------
  // divide by compare value plus one
  // ----------------------------------------
  assign tick = running & (pre_cnt_reg == prescale_compare_value); // R12

  always @* begin
    pre_cnt_next = pre_cnt_reg;
    if (!running) begin
      pre_cnt_next = {PRE_W{1'b0}};
    end else if (tick) begin
      pre_cnt_next = {PRE_W{1'b0}}; // R12
    end else begin
      pre_cnt_next = pre_cnt_reg + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pre_cnt_reg <= `TPD_PRE_RESET;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

endmodule

// *** logic/tpd_top.v ***
// period/duty compare and capture registers for four timer subsystems
`timescale 1ns/1ps
`include "tpd_defines.vh"

// What this block does
// (R1) one 16-bit read/write period/capture register for each of four subsystems
// (R2) period register holds period compare in pwm, counter at capture otherwise
// (R3) period double buffered; write applies at previous-period match or when stopped
// (R4) reads allowed any time, returning the most recently written value
// (R5) reset clears all four period/capture registers
// (R6) one 16-bit duty/capture register per subsystem, compare or captured count
// (R7) duty double buffered; applied only at period boundary or when stopped
// (R8) reset clears all four duty/capture registers
// (R9) each register is one word at an even address, word access only
// (R10) software writes reserved bits as zero; reserved reads are undefined
// (R11) counter counts as stopped only when both run bits are clear
// (R12) counter advances once per prescaler match, ratio compare value plus one
// (R13) period and duty pending values of one subsystem transfer together
// (R14) capture loads the counter one cycle after the event is seen

module tpd_top #(
  parameter DATA_W  = `TPD_DATA_W,
  parameter PRE_W   = `TPD_PRE_W,
  parameter NUM_SUB = `TPD_NUM_SUB,
  parameter ADDR_W  = `TPD_ADDR_W
) (
  input  wire                      ref_clk,
  input  wire                      srst,
  input  wire [ADDR_W-1:0]         bus_addr,
  input  wire                      bus_wr,
  input  wire                      bus_rd,
  input  wire [DATA_W-1:0]         bus_wdata,
  output wire [DATA_W-1:0]         bus_rdata,
  output wire                      bus_rvalid,
  input  wire [2*NUM_SUB-1:0]      subsystem_run_bits,
  input  wire [NUM_SUB-1:0]        pwm_mode,
  input  wire [NUM_SUB-1:0]        capture_period_evt,
  input  wire [NUM_SUB-1:0]        capture_duty_evt,
  input  wire [NUM_SUB*PRE_W-1:0]  prescale_compare_value,
  output wire [NUM_SUB*DATA_W-1:0] subsystem_counter,
  output wire [NUM_SUB*DATA_W-1:0] period_active,
  output wire [NUM_SUB*DATA_W-1:0] duty_active,
  output wire [NUM_SUB-1:0]        period_match,
  output wire [NUM_SUB-1:0]        update_pending
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  reg  [DATA_W-1:0]         rdata_reg;
  reg  [DATA_W-1:0]         rdata_next;
  reg                       rvalid_reg;
  wire                      word_ok;
  reg  [NUM_SUB-1:0]        period_wr;
  reg  [NUM_SUB-1:0]        duty_wr;
  wire [NUM_SUB*DATA_W-1:0] period_read;
  wire [NUM_SUB*DATA_W-1:0] duty_read;
  wire [NUM_SUB-1:0]        stopped;
  wire [NUM_SUB-1:0]        period_pend;
  wire [NUM_SUB-1:0]        duty_pend;

  // odd addresses are not word aligned and are ignored
  assign word_ok    = ~bus_addr[0]; // R9
  assign bus_rdata  = rdata_reg;
  assign bus_rvalid = rvalid_reg;

  always @* begin
    period_wr = {NUM_SUB{1'b0}};
    duty_wr   = {NUM_SUB{1'b0}};
    if (bus_wr && word_ok) begin
      case (bus_addr)
        `TPD_OFS_PERIOD_1: begin
          period_wr[0] = 1'b1; // R1
        end
        `TPD_OFS_PERIOD_2: begin
          period_wr[1] = 1'b1;
        end
        `TPD_OFS_PERIOD_3: begin
          period_wr[2] = 1'b1;
        end
        `TPD_OFS_PERIOD_4: begin
          period_wr[3] = 1'b1;
        end
        `TPD_OFS_DUTY_1: begin
          duty_wr[0] = 1'b1; // R6
        end
        `TPD_OFS_DUTY_2: begin
          duty_wr[1] = 1'b1;
        end
        `TPD_OFS_DUTY_3: begin
          duty_wr[2] = 1'b1;
        end
        `TPD_OFS_DUTY_4: begin
          duty_wr[3] = 1'b1;
        end
        default: begin
          period_wr = {NUM_SUB{1'b0}};
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux, registered one cycle after the strobe
  // ----------------------------------------
  always @* begin
    rdata_next = `TPD_RDATA_IDLE;
    if (word_ok) begin
      case (bus_addr)
        `TPD_OFS_PERIOD_1: begin
          rdata_next = period_read[0*DATA_W +: DATA_W]; // R4
        end
        `TPD_OFS_PERIOD_2: begin
          rdata_next = period_read[1*DATA_W +: DATA_W];
        end
        `TPD_OFS_PERIOD_3: begin
          rdata_next = period_read[2*DATA_W +: DATA_W];
        end
        `TPD_OFS_PERIOD_4: begin
          rdata_next = period_read[3*DATA_W +: DATA_W];
        end
        `TPD_OFS_DUTY_1: begin
          rdata_next = duty_read[0*DATA_W +: DATA_W]; // R4
        end
        `TPD_OFS_DUTY_2: begin
          rdata_next = duty_read[1*DATA_W +: DATA_W];
        end
        `TPD_OFS_DUTY_3: begin
          rdata_next = duty_read[2*DATA_W +: DATA_W];
        end
        `TPD_OFS_DUTY_4: begin
          rdata_next = duty_read[3*DATA_W +: DATA_W];
        end
        default: begin
          rdata_next = `TPD_RDATA_IDLE;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      rdata_reg  <= `TPD_RDATA_IDLE;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus_rd;
      if (bus_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ----------------------------------------
  // per subsystem: prescaler, counter, two buffered registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SUB; g = g + 1) begin : sub
      reg  [DATA_W-1:0] cnt_reg;
      wire              tick;
      wire              at_period;
      wire [DATA_W-1:0] per_act;

      // either run bit keeps the counter going
      assign stopped[g] = ~(subsystem_run_bits[2*g] | subsystem_run_bits[2*g+1]); // R11
      assign at_period  = (cnt_reg == per_act);
      // compare against the previous active period, not the pending one
      assign period_match[g] = tick & pwm_mode[g] & at_period; // R3 R7
      assign subsystem_counter[g*DATA_W +: DATA_W] = cnt_reg;
      assign period_active[g*DATA_W +: DATA_W]     = per_act;
      assign update_pending[g] = period_pend[g] | duty_pend[g];

      tpd_prescaler #(
        .PRE_W (PRE_W)
      ) u_pre (
        .ref_clk                (ref_clk),
        .srst                   (srst),
        .running                (~stopped[g]),
        .prescale_compare_value (prescale_compare_value[g*PRE_W +: PRE_W]),
        .tick                   (tick)
      );

      // counter wraps to zero at the period in pwm, free runs in capture
      always @(posedge ref_clk) begin
        if (srst) begin
          cnt_reg <= `TPD_RESET_VAL;
        end else if (period_match[g]) begin
          cnt_reg <= {DATA_W{1'b0}};
        end else if (tick) begin
          cnt_reg <= cnt_reg + {{(DATA_W-1){1'b0}}, 1'b1}; // R12
        end
      end

      tpd_buffered_reg #(
        .DATA_W (DATA_W)
      ) u_period (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .wr_en        (period_wr[g]),
        .wdata        (bus_wdata),
        .pwm_mode     (pwm_mode[g]),
        .stopped      (stopped[g]),
        .period_match (period_match[g]),
        .capture_evt  (capture_period_evt[g]),
        .counter      (cnt_reg),
        .read_value   (period_read[g*DATA_W +: DATA_W]),
        .active_value (per_act),
        .pending      (period_pend[g])
      );

      // same match strobe as the period register: both move together
      tpd_buffered_reg #(
        .DATA_W (DATA_W)
      ) u_duty (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .wr_en        (duty_wr[g]),
        .wdata        (bus_wdata),
        .pwm_mode     (pwm_mode[g]),
        .stopped      (stopped[g]),
        .period_match (period_match[g]), // R13
        .capture_evt  (capture_duty_evt[g]),
        .counter      (cnt_reg),
        .read_value   (duty_read[g*DATA_W +: DATA_W]),
        .active_value (duty_active[g*DATA_W +: DATA_W]),
        .pending      (duty_pend[g])
      );
    end
  endgenerate

endmodule

// *** sim/testbench.sv ***
// self-checking bench for the timer period/duty register block
`timescale 1ns/1ps
`include "tpd_defines.vh"

module testbench;
  reg          ref_clk, srst, bus_wr, bus_rd;
  reg  [3:0]   bus_addr, pwm_mode, capture_period_evt, capture_duty_evt;
  reg  [15:0]  bus_wdata, last;
  reg  [7:0]   subsystem_run_bits;
  reg  [31:0]  prescale_compare_value;
  wire [15:0]  bus_rdata;
  wire         bus_rvalid;
  wire [63:0]  subsystem_counter, period_active, duty_active;
  wire [3:0]   period_match, update_pending;
  integer      mismatches, num_checks, i, g, n, p, seed_dummy;
  integer      model [0:7];

  tpd_top u_tpd_top (.ref_clk, .srst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata, .bus_rvalid, .subsystem_run_bits, .pwm_mode, .capture_period_evt,
    .capture_duty_evt, .prescale_compare_value, .subsystem_counter, .period_active,
    .duty_active, .period_match, .update_pending);

  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end

  task check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // odd addresses are dropped by the block, so the model skips them too
  task wr(input [3:0] a, input [15:0] d);
    @(negedge ref_clk);
    bus_wr = 1; bus_addr = a; bus_wdata = d;
    @(negedge ref_clk);
    bus_wr = 0;
    if (!a[0]) model[a[3:1]] = d;
  endtask
  // read lands on the edge right after the write: no idle cycle between them
  task wr_rd(input [3:0] a, input [15:0] d);
    @(negedge ref_clk);
    bus_wr = 1; bus_addr = a; bus_wdata = d;
    @(negedge ref_clk);
    bus_wr = 0;
    bus_rd = 1;
    if (!a[0]) model[a[3:1]] = d;
    @(negedge ref_clk);
    bus_rd = 0;
    check({15'h0000, bus_rvalid}, 16'h0001);
    check(bus_rdata, a[0] ? 16'h0000 : model[a[3:1]][15:0]);
  endtask
  task rd(input [3:0] a);
    @(negedge ref_clk);
    bus_rd = 1; bus_addr = a;
    @(negedge ref_clk);
    bus_rd = 0;
    check({15'h0000, bus_rvalid}, 16'h0001);
    check(bus_rdata, a[0] ? 16'h0000 : model[a[3:1]][15:0]);
  endtask
  task wait_change(output integer c);
    c = 0;
    last = subsystem_counter[15:0];
    while (subsystem_counter[15:0] === last && c < 600) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= 600) begin mismatches++; conclude; end
  endtask

  initial begin
    srst = 1; bus_wr = 0; bus_rd = 0; bus_addr = 0; bus_wdata = 0;
    subsystem_run_bits = 0; pwm_mode = 4'hf; capture_period_evt = 0;
    capture_duty_evt = 0; prescale_compare_value = 0; mismatches = 0; num_checks = 0;
    for (i = 0; i < 8; i++) model[i] = 0;
    seed_dummy = $urandom(63467);
    repeat (20) @(negedge ref_clk);
    srst = 0;
    for (i = 0; i < 8; i++) rd(2 * i);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      wr_rd(2 * i, $urandom);
    end
    wr(4'h3, 16'hdead);
    rd(4'h3);
    rd(4'h2);
    @(negedge ref_clk);
    for (g = 0; g < 4; g++) begin
      check(period_active[g*16+:16], model[g][15:0]);
      check(duty_active[g*16+:16], model[4+g][15:0]);
    end
    $display("test access done");
    // slow prescale keeps the first boundary far from the writes
    prescale_compare_value = {4{8'h0f}};
    for (g = 0; g < 4; g++) begin
      wr(2 * g, 16'h0008 + g);
      wr(8 + 2 * g, 16'h0003);
      @(negedge ref_clk);
      subsystem_run_bits[2*g+1] = 1;
      wr(2 * g, 16'h0014);
      wr(8 + 2 * g, 16'h000a);
      rd(2 * g);
      check(period_active[g*16+:16], 16'h0008 + g);
      check(duty_active[g*16+:16], 16'h0003);
      check({15'h0000, update_pending[g]}, 16'h0001);
      n = 0;
      while (update_pending[g] === 1'b1 && n < 600) begin
        @(negedge ref_clk);
        n++;
      end
      if (n >= 600) begin mismatches++; conclude; end
      check(period_active[g*16+:16], 16'h0014);
      check(duty_active[g*16+:16], 16'h000a);
      subsystem_run_bits[2*g+1] = 0;
    end
    $display("test buffering done");
    for (i = 0; i < 3; i++) begin
      p = $urandom % 4;
      prescale_compare_value[7:0] = p;
      subsystem_run_bits[0] = 1;
      wait_change(n);
      wait_change(n);
      check(n, p + 1);
      subsystem_run_bits[0] = 0;
      @(negedge ref_clk);
    end
    $display("test prescaler done");
    pwm_mode[1] = 0;
    prescale_compare_value[15:8] = 0;
    subsystem_run_bits[3] = 1;
    repeat (5) @(negedge ref_clk);
    capture_period_evt[1] = 1;
    @(negedge ref_clk);
    capture_period_evt[1] = 0;
    model[1] = subsystem_counter[31:16];
    capture_duty_evt[1] = 1;
    @(negedge ref_clk);
    capture_duty_evt[1] = 0;
    model[5] = subsystem_counter[31:16];
    rd(4'h2);
    rd(4'ha);
    capture_period_evt[0] = 1;
    @(negedge ref_clk);
    capture_period_evt[0] = 0;
    rd(4'h0);
    $display("test capture done");
    conclude;
  end
endmodule

// *** sim/tpd_monitor.sv ***
// concurrent checks on the ports of the timer period/duty register block
`timescale 1ns/1ps

module tpd_monitor #(
  parameter DATA_W  = 16,
  parameter PRE_W   = 8,
  parameter NUM_SUB = 4,
  parameter ADDR_W  = 4
) (
  input wire                      ref_clk,
  input wire                      srst,
  input wire [ADDR_W-1:0]         bus_addr,
  input wire                      bus_wr,
  input wire                      bus_rd,
  input wire [DATA_W-1:0]         bus_wdata,
  input wire [DATA_W-1:0]         bus_rdata,
  input wire                      bus_rvalid,
  input wire [2*NUM_SUB-1:0]      subsystem_run_bits,
  input wire [NUM_SUB-1:0]        pwm_mode,
  input wire [NUM_SUB-1:0]        capture_period_evt,
  input wire [NUM_SUB-1:0]        capture_duty_evt,
  input wire [NUM_SUB*PRE_W-1:0]  prescale_compare_value,
  input wire [NUM_SUB*DATA_W-1:0] subsystem_counter,
  input wire [NUM_SUB*DATA_W-1:0] period_active,
  input wire [NUM_SUB*DATA_W-1:0] duty_active,
  input wire [NUM_SUB-1:0]        period_match,
  input wire [NUM_SUB-1:0]        update_pending
);
  // only subsystem 0 is watched, except the reset, odd-read and write/read-back checks cover all four; the others share the same logic
  wire st0 = (subsystem_run_bits[1:0] == 2'b00);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_wr_p0_stopped;
    st0 && pwm_mode[0] && bus_wr && bus_addr == 4'h0 ##1 st0;
  endsequence
  sequence s_wr_then_rd;
    bus_wr && !bus_addr[0] && (&pwm_mode) ##1
      bus_rd && !bus_wr && (&pwm_mode) && bus_addr == $past(bus_addr);
  endsequence
  a_reset_clears_all: assert property (disable iff (1'b0) srst |=> bus_rdata == 0 &&
    !bus_rvalid && period_active == 0 && duty_active == 0 && update_pending == 0)
    else $error("state not cleared by reset");
  a_read_answers_next: assert property (bus_rd |=> bus_rvalid)
    else $error("read not answered");
  a_no_stray_rvalid: assert property (!bus_rd |=> !bus_rvalid)
    else $error("rvalid without read");
  a_odd_read_zero: assert property (bus_rd && bus_addr[0] |=> bus_rdata == 0)
    else $error("odd address read not zero");
  a_write_read_back: assert property (s_wr_then_rd |=> bus_rdata == $past(bus_wdata, 2))
    else $error("read after write lost value");
  a_stopped_applies: assert property (s_wr_p0_stopped |=>
    period_active[DATA_W-1:0] == $past(bus_wdata, 2))
    else $error("stopped write not applied");
  a_running_write_waits: assert property (!st0 && pwm_mode[0] && bus_wr &&
    bus_addr == 4'h0 && !period_match[0] |=> update_pending[0])
    else $error("running write not pending");
  a_active_held_run: assert property (!st0 && pwm_mode[0] && !period_match[0] |=>
    $stable(period_active[DATA_W-1:0]) && $stable(duty_active[DATA_W-1:0]))
    else $error("active value moved off boundary");
  a_match_clears_pend: assert property (period_match[0] && !bus_wr |=> !update_pending[0])
    else $error("pending kept past match");
  a_match_wraps_count: assert property (period_match[0] |=>
    subsystem_counter[DATA_W-1:0] == 0)
    else $error("counter did not wrap");
  a_match_cause: assert property (period_match[0] |-> pwm_mode[0] && !st0 &&
    subsystem_counter[DATA_W-1:0] == period_active[DATA_W-1:0])
    else $error("match without cause");
endmodule

bind tpd_top tpd_monitor #(.DATA_W(DATA_W), .PRE_W(PRE_W), .NUM_SUB(NUM_SUB),
  .ADDR_W(ADDR_W)) u_tpd_monitor (.ref_clk, .srst, .bus_addr, .bus_wr, .bus_rd,
  .bus_wdata, .bus_rdata, .bus_rvalid, .subsystem_run_bits, .pwm_mode,
  .capture_period_evt, .capture_duty_evt, .prescale_compare_value,
  .subsystem_counter, .period_active, .duty_active, .period_match, .update_pending);
